// ===== bench/jtag_host_model.sv
// Test controller model driving the test access port
`timescale 1ns/100ps
`default_nettype none
module jtag_host_model (
  // Test access port
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck    = 1'b0;
    trst_n = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
  end
  // ----------------------------------------------------------------
  // One test clock; it stands low between frames
  // ----------------------------------------------------------------
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16 q = tdo;
    tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  // Reset needs clock edges, so pulse it with tms high
  task automatic tap_reset();
    logic q;
    trst_n = 1'b0;
    repeat (5) step(1'b1, 1'b0, q);
    trst_n = 1'b1;
    step(1'b0, 1'b0, q);
  endtask
  // Instruction or data scan from idle back to idle, bit 0 first
  task automatic scan(input logic ir, input int len, input logic [21:0] din, output logic [21:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~din[len-1], q);
    step(1'b0, din[len-1], q);
  endtask
endmodule // jtag_host_model
`default_nettype wire

// ===== bench/repeater_ctrl_tb.sv
// Self-checking bench for the repeater control and scan logic
`timescale 1ns/100ps
`default_nettype none
module repeater_ctrl_tb;
  import repeater_pkg::*;
  typedef struct packed {
    int unsigned due;
    logic [9:0]  val;
  } note_t;
  logic           clk, rst, power_down_n, emphasis_sel_msb, emphasis_sel_lsb;
  logic           tck, trst_n, tms, tdi, tdo, tdo_oe, bias_enable, input_buf_en;
  logic [NCH-1:0] data_in, data_out, data_out_oe, prev;
  emph_t          emphasis_level;
  note_t          notes[$];
  int unsigned    cyc, fail_count, checked;
  int             n;
  integer         seed;
  logic [21:0]    sh;

  repeater_ctrl i_dut (.clk(clk), .rst(rst), .power_down_n(power_down_n), .emphasis_sel_msb(emphasis_sel_msb),
    .emphasis_sel_lsb(emphasis_sel_lsb), .data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe),
    .emphasis_level(emphasis_level), .bias_enable(bias_enable), .input_buf_en(input_buf_en), .tck(tck),
    .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  jtag_host_model i_host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

  // ----------------------------------------------------------------
  // Clock, cycle count, checking
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Oldest note is compared when its cycle comes round
  always @(negedge clk) begin
    if (notes.size() > 0 && notes[0].due == cyc) begin
      check(22'({data_out_oe, emphasis_level, data_out}), 22'(notes[0].val));
      void'(notes.pop_front());
    end
  end

  // Bounded waits; a used-up bound ends the run
  task automatic wait_oe(input logic [3:0] oe, input int lim, output int k);
    k = 0;
    while (data_out_oe !== oe && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (data_out_oe !== oe) begin
      check(22'(data_out_oe), 22'(oe));
      final_report();
    end
  endtask

  task automatic expect_pins(input logic [3:0] d, input int lim);
    int k;
    k = 0;
    while (data_out !== d && k < lim) begin
      @(negedge clk);
      k++;
    end
    check(22'({data_out_oe, data_out}), 22'({4'hf, d}));
    if (data_out !== d) final_report();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    power_down_n = 1'b1;
    emphasis_sel_msb = 1'b0;
    emphasis_sel_lsb = 1'b0;
    data_in = 4'h0;
    seed = 32'ha9cb;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    repeat (4) @(negedge clk);
    check(22'({data_out_oe, bias_enable, input_buf_en}), 22'h0);
    rst = 1'b0;
    i_host.tap_reset();
    @(negedge clk);
    wait_oe(4'hf, 20, n);
    // Every emphasis code with random channel data
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      {emphasis_sel_msb, emphasis_sel_lsb} = 2'(i / 6);
      data_in = 4'($random(seed));
      notes.push_back(note_t'{cyc + 3, {4'hf, 2'(i / 6), data_in}});
    end
    repeat (4) @(negedge clk);
    check(22'(notes.size()), 22'h0);
    $display("test functional done");
    // Powerdown with scan traffic inside it
    power_down_n = 1'b0;
    wait_oe(4'h0, 3, n);
    check(22'({bias_enable, input_buf_en, emphasis_level}), 22'h0);
    i_host.scan(1'b1, IR_LEN, 22'(IR_BYPASS), sh);
    check(22'(sh[IR_LEN-1:0]), 22'(IR_CAPTURE));
    i_host.scan(1'b0, 8, 22'ha5, sh);
    check(22'(sh[7:0]), 22'h4a);
    @(negedge clk);
    check(22'(data_out_oe), 22'h0);
    check(22'(tdo_oe), 22'h0);
    power_down_n = 1'b1;
    repeat (3) @(negedge clk);
    check(22'(data_out_oe), 22'h0);
    wait_oe(4'hf, 4, n);
    $display("test powerdown done");
    // Boundary drive: outputs 4'h9, enable cell set
    data_in = 4'h6;
    i_host.scan(1'b1, IR_LEN, 22'(IR_EXTEST), sh);
    i_host.scan(1'b0, BSR_LEN, 22'hc80, sh);
    check(22'(sh[6:0]), 22'h37);
    expect_pins(4'h9, 20);
    $display("test boundary done");
    // Toggling drive for coupled links
    i_host.scan(1'b1, IR_LEN, 22'(IR_AC), sh);
    i_host.scan(1'b0, BSR_LEN, 22'hc80, sh);
    repeat (20) @(negedge clk);
    prev = data_out;
    @(negedge clk);
    check(22'({data_out_oe, data_out}), 22'({4'hf, ~prev}));
    $display("test toggle done");
    // Output 0 stuck high, output 1 stuck low, then cleared by reset
    data_in = 4'h2;
    i_host.scan(1'b1, IR_LEN, 22'(IR_STUCK), sh);
    i_host.scan(1'b0, 22, 22'h0c0080, sh);
    i_host.scan(1'b1, IR_LEN, 22'(IR_BYPASS), sh);
    expect_pins(4'h1, 30);
    i_host.tap_reset();
    expect_pins(4'h2, 30);
    $display("test stuck done");
    final_report();
  end
endmodule // repeater_ctrl_tb
`default_nettype wire

// ===== core/repeater_ctrl.sv
// Repeater powerdown, emphasis, channel path and boundary-scan port
`timescale 1ns/100ps
`default_nettype none
module repeater_ctrl
  import repeater_pkg::*;
(
  // System clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Control pins
  input  wire logic           power_down_n,
  input  wire logic           emphasis_sel_msb,
  input  wire logic           emphasis_sel_lsb,
  // Channels
  input  wire logic [NCH-1:0] data_in,
  output logic      [NCH-1:0] data_out,
  output logic      [NCH-1:0] data_out_oe,
  output emph_t               emphasis_level,
  output logic                bias_enable,
  output logic                input_buf_en,
  // Test access port
  input  wire logic           tck,
  input  wire logic           trst_n,
  input  wire logic           tms,
  input  wire logic           tdi,
  output logic                tdo,
  output logic                tdo_oe
);

  // ----------------------------------------------------------------
  // System side: pin view with faults applied
  // ----------------------------------------------------------------
  logic [NIN-1:0] pin_sync;
  test_word_t     test;
  pwr_t           st;
  pwr_t           next_st;
  logic [WAKE_W-1:0] wake_cnt;
  logic           ac_phase;
  logic           req_clk;
  logic           ack_clk;
  logic           tlr_clk;

  sync_2ff #(.WIDTH(NIN)) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({data_in, emphasis_sel_lsb, emphasis_sel_msb, power_down_n}),
    .q   (pin_sync)
  );

  wire [NIN-1:0] in_mask  = test.stuck_mask[NIN-1:0];
  wire [NIN-1:0] in_view  = (pin_sync & ~in_mask) | (test.stuck_val[NIN-1:0] & in_mask);
  wire           pwr_req  = in_view[PIN_POWER_DOWN_N];
  wire [1:0]     emph_sel = {in_view[PIN_EMSB], in_view[PIN_ELSB]};
  wire [NCH-1:0] din_view = in_view[PIN_DIN +: NCH];

  // ----------------------------------------------------------------
  // Power sequencing
  // ----------------------------------------------------------------
  always_comb begin
    case (st)
      PWR_OFF:  next_st = pwr_req ? PWR_WAKE : PWR_OFF;
      PWR_WAKE: next_st = !pwr_req ? PWR_OFF : (wake_cnt == WAKE_LAST) ? PWR_ON : PWR_WAKE;
      PWR_ON:   next_st = pwr_req ? PWR_ON : PWR_OFF;
      default:  next_st = PWR_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st       <= PWR_OFF;
      wake_cnt <= '0;
      ac_phase <= 1'b0;
    end else begin
      st       <= next_st;
      wake_cnt <= (st == PWR_WAKE) ? wake_cnt + 1'b1 : '0;
      ac_phase <= ~ac_phase;
    end
  end

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  // AC mode toggles the driven level so coupling caps pass an edge
  wire [NCH-1:0] ac_val    = test.drive ^ {NCH{ac_phase}};
  wire [NCH-1:0] drive_val = (test.mode == MODE_FUNC) ? din_view :
                             (test.mode == MODE_AC) ? ac_val : test.drive;
  wire [NCH-1:0] out_mask  = test.stuck_mask[PIN_DOUT +: NCH];
  wire [NCH-1:0] next_out  = (drive_val & ~out_mask) | (test.stuck_val[PIN_DOUT +: NCH] & out_mask);
  // Synced level gates too, so release does not wait for the state change
  wire           next_oe   = (st == PWR_ON) && pwr_req && (test.mode == MODE_FUNC || test.drive_oe);

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out       <= '0;
      data_out_oe    <= '0;
      emphasis_level <= EMPH_OFF;
      bias_enable    <= 1'b0;
      input_buf_en   <= 1'b0;
    end else begin
      data_out       <= next_out;
      data_out_oe    <= {NCH{next_oe}};
      emphasis_level <= pwr_req ? emph_t'(emph_sel) : EMPH_OFF;
      bias_enable    <= pwr_req;
      input_buf_en   <= pwr_req;
    end
  end

  // ----------------------------------------------------------------
  // Test word crossing, system side
  // ----------------------------------------------------------------
  logic       hs_req;
  test_word_t hold;

  sync_2ff #(.WIDTH(1)) u_req_sync (
    .clk (clk),
    .rst (rst),
    .d   (hs_req),
    .q   (req_clk)
  );

  // Hold is frozen until the ack returns, so sampling it here is safe
  always_ff @(posedge clk) begin
    if (rst) begin
      test    <= TEST_WORD_RST;
      ack_clk <= 1'b0;
    end else begin
      ack_clk <= req_clk;
      // Port reset sends no update, so its level clears the word here
      if (tlr_clk) begin
        test <= TEST_WORD_RST;
      end else if (req_clk != ack_clk) begin
        test <= hold;
      end
    end
  end

  // ----------------------------------------------------------------
  // Test clock domain
  // ----------------------------------------------------------------
  wire tck_rst = ~trst_n;
  logic [BSR_LEN-1:0]  cap_tck;
  logic                ack_tck;
  tap_t                tap;
  tap_t                next_tap;
  logic [IR_LEN-1:0]   ir;
  logic [IR_LEN-1:0]   ir_shift;
  logic [BSR_LEN-1:0]  bsr;
  logic [BSR_LEN-1:0]  bsr_upd;
  logic [2*NPIN-1:0]   stuck_shift;
  logic [2*NPIN-1:0]   stuck_upd;
  logic                bypass_bit;
  logic                pending;
  logic                tlr_tck;
  test_word_t          live;

  sync_2ff #(.WIDTH(1)) u_tlr_sync (
    .clk (clk),
    .rst (rst),
    .d   (tlr_tck),
    .q   (tlr_clk)
  );

  sync_2ff #(.WIDTH(BSR_LEN)) u_cap_sync (
    .clk (tck),
    .rst (tck_rst),
    .d   ({data_out_oe[0], data_out, pin_sync}),
    .q   (cap_tck)
  );

  sync_2ff #(.WIDTH(1)) u_ack_sync (
    .clk (tck),
    .rst (tck_rst),
    .d   (ack_clk),
    .q   (ack_tck)
  );

  always_comb begin
    case (tap)
      TAP_TLR:    next_tap = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI:    next_tap = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  next_tap = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: next_tap = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  next_tap = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = tms ? TAP_SEL_DR : TAP_RTI;
      default:    next_tap = TAP_TLR;
    endcase
  end

  wire sel_bsr   = (ir == IR_EXTEST) || (ir == IR_SAMPLE) || (ir == IR_AC);
  wire sel_stuck = (ir == IR_STUCK);
  wire dr_out    = sel_bsr ? bsr[0] : sel_stuck ? stuck_shift[0] : bypass_bit;
  wire next_tdo  = (tap == TAP_SH_IR) ? ir_shift[0] : dr_out;
  wire shifting  = (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
  wire updating  = (tap == TAP_UPD_IR) || (tap == TAP_UPD_DR);

  // Word as it stands after this edge, so an update can leave at once
  wire [IR_LEN-1:0]  ir_new    = (tap == TAP_UPD_IR) ? ir_shift : ir;
  wire [BSR_LEN-1:0] bsr_new   = (tap == TAP_UPD_DR && sel_bsr) ? bsr : bsr_upd;
  wire [2*NPIN-1:0]  stuck_new = (tap == TAP_UPD_DR && sel_stuck) ? stuck_shift : stuck_upd;

  assign live.mode       = (ir_new == IR_EXTEST) ? MODE_EXTEST : (ir_new == IR_AC) ? MODE_AC : MODE_FUNC;
  assign live.drive      = bsr_new[PIN_DOUT +: NCH];
  assign live.drive_oe   = bsr_new[BSR_OE];
  assign live.stuck_mask = stuck_new[NPIN +: NPIN];
  assign live.stuck_val  = stuck_new[NPIN-1:0];

  always_ff @(posedge tck) begin
    if (tck_rst || tap == TAP_TLR) begin
      tap       <= tck_rst ? TAP_TLR : next_tap;
      ir        <= IR_BYPASS;
      ir_shift  <= '0;
      stuck_upd <= '0; // Faults clear on test logic reset
    end else begin
      tap <= next_tap;
      case (tap)
        TAP_CAP_IR: ir_shift <= IR_CAPTURE;
        TAP_SH_IR:  ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};
        TAP_UPD_IR: ir <= ir_shift;
        TAP_UPD_DR: if (sel_stuck) stuck_upd <= stuck_shift;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      bsr         <= '0;
      bsr_upd     <= '0;
      stuck_shift <= '0;
      bypass_bit  <= 1'b0;
    end else begin
      case (tap)
        TAP_CAP_DR: begin
          bsr         <= cap_tck;
          stuck_shift <= stuck_upd;
          bypass_bit  <= 1'b0;
        end
        TAP_SH_DR: begin
          if (sel_bsr) bsr <= {tdi, bsr[BSR_LEN-1:1]};
          if (sel_stuck) stuck_shift <= {tdi, stuck_shift[2*NPIN-1:1]};
          bypass_bit <= tdi;
        end
        TAP_UPD_DR: if (sel_bsr) bsr_upd <= bsr;
        default:    ;
      endcase
    end
  end

  // Send on the update edge itself: the test clock may stop right after it
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      hs_req  <= 1'b0;
      pending <= 1'b0;
      hold    <= TEST_WORD_RST;
      tlr_tck <= 1'b1;
    end else begin
      tlr_tck <= (next_tap == TAP_TLR);
      if ((updating || pending) && hs_req == ack_tck) begin
        hold    <= live;
        hs_req  <= ~hs_req;
        pending <= 1'b0;
      end else begin
        pending <= updating || pending;
      end
    end
  end

  // Test data out changes on the falling edge
  always_ff @(negedge tck) begin
    if (tck_rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= next_tdo;
      tdo_oe <= shifting;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int A_ON_MAX  = ON_CYC;
  localparam int A_OFF_MAX = OFF_CYC;

  a_off_hiz: assert property (@(posedge clk) disable iff (rst)
    $fell(pwr_req) |-> ##[1:A_OFF_MAX] (data_out_oe == '0))
    else $error("outputs not released on powerdown");
  a_pd_hold: assert property (@(posedge clk) disable iff (rst)
    !pwr_req ##1 !pwr_req |-> (data_out_oe == '0))
    else $error("output driven during powerdown");
  a_bias_off: assert property (@(posedge clk) disable iff (rst)
    !pwr_req |=> !bias_enable && !input_buf_en)
    else $error("buffers or bias left on in powerdown");
  a_wake_quiet: assert property (@(posedge clk) disable iff (rst)
    $rose(pwr_req) |=> (data_out_oe == '0) [*2])
    else $error("output active during start-up");
  a_wake_on: assert property (@(posedge clk) disable iff (rst)
    $rose(pwr_req) && test.mode == MODE_FUNC |-> ##[1:A_ON_MAX] (data_out_oe != '0 || !pwr_req))
    else $error("output not active after start-up");
  a_emph_map: assert property (@(posedge clk) disable iff (rst)
    pwr_req |=> emphasis_level == emph_t'($past(emph_sel)))
    else $error("emphasis level wrong");
  a_func_copy: assert property (@(posedge clk) disable iff (rst)
    test.mode == MODE_FUNC && out_mask == '0 |=> data_out == $past(din_view))
    else $error("channel does not follow input");
  a_stuck_out: assert property (@(posedge clk) disable iff (rst)
    out_mask[0] |=> data_out[0] == $past(test.stuck_val[PIN_DOUT]))
    else $error("stuck-at not applied");
  a_ac_toggle: assert property (@(posedge clk) disable iff (rst)
    test.mode == MODE_AC && out_mask == '0 && $stable(test) |=> data_out != $past(data_out))
    else $error("AC test output not toggling");
  a_tap_reset: assert property (@(posedge tck) disable iff (tck_rst)
    tms [*5] |=> tap == TAP_TLR)
    else $error("five tms highs did not reset the port");
  a_bsr_capture: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_CAP_DR && sel_bsr |=> bsr == $past(cap_tck))
    else $error("boundary capture wrong");
  a_tap_frozen: assert property (@(posedge tck) disable iff (tck_rst)
    !cap_tck[PIN_POWER_DOWN_N] && tap == TAP_SH_DR && !tms |=> tap == TAP_SH_DR)
    else $error("scan port disturbed in powerdown");

endmodule // repeater_ctrl
`default_nettype wire

// ===== core/repeater_pkg.sv
// Constants, types and carriers shared by the repeater control and test logic
package repeater_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 40;
  localparam int ON_MAX_NS   = 300;
  localparam int OFF_MAX_NS  = 12;
  localparam int STARTUP_NS  = 120;
  localparam int ON_CYC      = (ON_MAX_NS / CLK_NS < 1) ? 1 : ON_MAX_NS / CLK_NS;
  localparam int OFF_CYC     = (OFF_MAX_NS / CLK_NS < 1) ? 1 : OFF_MAX_NS / CLK_NS;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_W      = 2;
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(STARTUP_CYC - 1);

  // ----------------------------------------------------------------
  // Pin map of the scan chain
  // ----------------------------------------------------------------
  localparam int NCH      = 4;
  localparam int NIN      = 7;
  localparam int NPIN     = 11;
  localparam int BSR_LEN  = 12;
  localparam int PIN_POWER_DOWN_N = 0;
  localparam int PIN_EMSB = 1;
  localparam int PIN_ELSB = 2;
  localparam int PIN_DIN  = 3;
  localparam int PIN_DOUT = 7;
  localparam int BSR_OE   = 11;

  // ----------------------------------------------------------------
  // Instructions
  // ----------------------------------------------------------------
  localparam int IR_LEN = 4;
  localparam logic [IR_LEN-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_LEN-1:0] IR_SAMPLE  = 4'h1;
  localparam logic [IR_LEN-1:0] IR_STUCK   = 4'h4;
  localparam logic [IR_LEN-1:0] IR_AC      = 4'h8;
  localparam logic [IR_LEN-1:0] IR_BYPASS  = 4'hf;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EMPH_OFF = 2'b00, EMPH_LOW = 2'b01, EMPH_MED = 2'b10, EMPH_HIGH = 2'b11
  } emph_t;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00, PWR_WAKE = 2'b01, PWR_ON = 2'b10
  } pwr_t;

  typedef enum logic [1:0] {
    MODE_FUNC = 2'b00, MODE_EXTEST = 2'b01, MODE_AC = 2'b10
  } test_mode_t;

  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
  } tap_t;

  typedef struct packed {
    test_mode_t      mode;
    logic [NCH-1:0]  drive;
    logic            drive_oe;
    logic [NPIN-1:0] stuck_mask;
    logic [NPIN-1:0] stuck_val;
  } test_word_t;

  localparam test_word_t TEST_WORD_RST = '0;

endpackage

// ===== core/sync_2ff.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync_2ff
`default_nettype wire
